// ---- core/tsw_regs.svh ----
/*
 * Register offsets, field positions, reset values and counts of the
 * TDM switch mode and reset register bank.
 * Assumes a 32-bit AXI4-Lite bus with byte addresses; index times four.
 */
// How it works
// - With the enable bit set, writing one to start bit 0 of the mode select register launches block programming.
// - A launched block programming run lasts two frames.
// - When the run ends the device clears the start bit itself, so software sees completion.
// - During a run, writing low to the start bit or to the enable bit aborts it.
// - With switch soft reset bit 1 low the switching blocks run normally.
// - With switch soft reset bit 1 high the switching blocks are held in reset.
// - Bit 8 of the output enable register enables offset frame pulse two.
// - During a run the three-bit pattern goes into bits 2 to 0 of each low memory word.
// - A low offset pulse enable bit puts that offset pulse output in high impedance.
// - A clock and pulse enable bit drives its clock and frame pulse, else both float.
`ifndef TSW_REGS_SVH
`define TSW_REGS_SVH

// Register indexes, byte address is index times four
`define TSW_IDX_MODE 4'h1
`define TSW_IDX_RSTCTL 4'h2
`define TSW_IDX_OUTEN 4'h3
`define TSW_IDX_BPCTL 4'h5
`define TSW_IDX_STAT 4'h8
`define TSW_IDX_CLR 4'h9
`define TSW_IDX_IEN 4'hA

// Writable bit masks, reserved bits read zero
`define TSW_MODE_MASK 16'h017F
`define TSW_RSTCTL_MASK 16'h0002
`define TSW_OCF_MASK 16'h01CF
`define TSW_BPCTL_MASK 16'h0001
`define TSW_IRQ_MASK 16'h0003

// Reset values
`define TSW_MODE_RST 16'h0000
`define TSW_RSTCTL_RST 16'h0000
`define TSW_OCF_RST 16'h0000

// Field positions
`define TSW_MODE_START 0
`define TSW_MODE_PAT_LSB 1
`define TSW_RSTCTL_SWITCH 1
`define TSW_OCF_OFF_LSB 6
`define TSW_BPCTL_EN 0
`define TSW_ST_DONE 0
`define TSW_ST_ABORT 1

// Frames per block programming run
`define TSW_BP_FRAMES 2'h2

// Bus responses
`define TSW_RESP_OKAY 2'h0
`define TSW_RESP_SLVERR 2'h2

`endif

// ---- core/tsw_pkg.sv ----
/*
 * Types of the TDM switch mode and reset register bank.
 * Assumes nothing of its surroundings.
 */
package tsw_pkg;

    // Block programming sequencer, one-hot
    typedef enum logic [1:0] {
        tsw_bp_idle = 2'h1,
        tsw_bp_run = 2'h2
    } tsw_bp_state_t;

endpackage

// ---- core/tsw_mode_reset.sv ----
/*
 * Mode select, software reset and output enable registers of a TDM switch,
 * with the block programming sequencer and an event interrupt.
 * Assumes a one-cycle frame pulse on frame_pulse in the aclk domain and an
 * AXI4-Lite master that keeps one write and one read outstanding at most.
 */
`timescale 1ns/1ps
`include "tsw_regs.svh"

module tsw_mode_reset (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Frame timing and output sources
    input wire logic frame_pulse,
    input wire logic [2:0] offset_pulse_src,
    input wire logic [3:0] clk_src,
    input wire logic [3:0] frame_src,
    // Block programming towards connection memory
    output logic bp_active,
    output logic [2:0] bp_pattern,
    // Switching block reset
    output logic switch_soft_reset,
    // Offset frame pulse pins
    output logic [2:0] offset_frame_pulse_o,
    output logic [2:0] offset_frame_pulse_oe,
    // Output clock and frame pulse pins
    output logic [3:0] output_clock_o,
    output logic [3:0] output_clock_oe,
    output logic [3:0] output_frame_pulse_o,
    output logic [3:0] output_frame_pulse_oe,
    // Interrupt
    output logic irq
);

    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_fire;
    logic [3:0] wr_idx;
    logic wr_ok;
    logic [3:0] rd_idx;
    logic [15:0] rd_val;
    logic rd_ok;
    logic [15:0] mode_q;
    logic [15:0] rstctl_q;
    logic [15:0] ocf_q;
    logic bp_enable_q;
    logic [15:0] stat_q;
    logic [15:0] ien_q;
    tsw_pkg::tsw_bp_state_t state_q;
    logic [1:0] frame_cnt_q;
    logic wr_mode;
    logic wr_bpctl;
    logic [15:0] mode_d;
    logic [15:0] bpctl_d;
    logic start_req;
    logic abort_req;
    logic done_evt;
    logic bp_active_q;
    logic [2:0] bp_pattern_q;
    logic swrst_q;
    logic irq_q;

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] data,
                                            input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] v;
        v = old_v;
        if (strb[0])
        begin
            v[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            v[15:8] = data[15:8];
        end
        return v & mask;
    endfunction

    // Address and data are taken together, one write at a time
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && awready_q && wready_q;
    assign wr_idx = s_axi_awaddr[5:2];
    assign wr_ok = (wr_idx == `TSW_IDX_MODE) || (wr_idx == `TSW_IDX_RSTCTL) ||
                   (wr_idx == `TSW_IDX_OUTEN) || (wr_idx == `TSW_IDX_BPCTL) ||
                   (wr_idx == `TSW_IDX_CLR) || (wr_idx == `TSW_IDX_IEN);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `TSW_RESP_OKAY;
        end
        else
        begin
            // Ready pulses for one cycle so a held valid is not taken twice
            awready_q <= s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
            wready_q <= s_axi_awvalid && s_axi_wvalid && !wready_q && !bvalid_q;
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? `TSW_RESP_OKAY : `TSW_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read decode; write-only clear register reads zero
    assign rd_idx = s_axi_araddr[5:2];
    always_comb
    begin
        rd_val = 16'h0000;
        rd_ok = 1'b1;
        case (rd_idx)
            `TSW_IDX_MODE: rd_val = mode_q;
            `TSW_IDX_RSTCTL: rd_val = rstctl_q;
            `TSW_IDX_OUTEN: rd_val = ocf_q;
            `TSW_IDX_BPCTL: rd_val = {15'h0000, bp_enable_q};
            `TSW_IDX_STAT: rd_val = stat_q;
            `TSW_IDX_CLR: rd_val = 16'h0000;
            `TSW_IDX_IEN: rd_val = ien_q;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `TSW_RESP_OKAY;
        end
        else
        begin
            arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
            if (s_axi_arvalid && arready_q)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= {16'h0000, rd_val};
                rresp_q <= rd_ok ? `TSW_RESP_OKAY : `TSW_RESP_SLVERR;
            end
            else if (s_axi_rready)
            begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Block programming launch and abort decode
    assign wr_mode = wr_fire && (wr_idx == `TSW_IDX_MODE);
    assign wr_bpctl = wr_fire && (wr_idx == `TSW_IDX_BPCTL);
    assign mode_d = merge16(mode_q, s_axi_wdata, s_axi_wstrb, `TSW_MODE_MASK);
    assign bpctl_d = merge16({15'h0000, bp_enable_q}, s_axi_wdata, s_axi_wstrb, `TSW_BPCTL_MASK);
    // Launch needs the enable already set; a rewrite while running is no launch
    assign start_req = wr_mode && mode_d[`TSW_MODE_START] && bp_enable_q &&
                       (state_q == tsw_pkg::tsw_bp_idle);
    assign abort_req = (state_q == tsw_pkg::tsw_bp_run) &&
                       ((wr_mode && !mode_d[`TSW_MODE_START]) ||
                        (wr_bpctl && !bpctl_d[`TSW_BPCTL_EN]));
    assign done_evt = (state_q == tsw_pkg::tsw_bp_run) && !abort_req && frame_pulse &&
                      (frame_cnt_q == `TSW_BP_FRAMES - 2'h1);

    // Sequencer: counts frame pulses while running
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= tsw_pkg::tsw_bp_idle;
            frame_cnt_q <= 2'h0;
        end
        else
        begin
            case (state_q)
                tsw_pkg::tsw_bp_idle:
                begin
                    frame_cnt_q <= 2'h0;
                    if (start_req)
                    begin
                        state_q <= tsw_pkg::tsw_bp_run;
                    end
                end
                tsw_pkg::tsw_bp_run:
                begin
                    if (abort_req || done_evt)
                    begin
                        state_q <= tsw_pkg::tsw_bp_idle;
                        frame_cnt_q <= 2'h0;
                    end
                    else if (frame_pulse)
                    begin
                        frame_cnt_q <= frame_cnt_q + 2'h1;
                    end
                end
                default:
                begin
                    state_q <= tsw_pkg::tsw_bp_idle;
                    frame_cnt_q <= 2'h0;
                end
            endcase
        end
    end

    // Mode select register; start bit owned by the sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_q <= `TSW_MODE_RST;
        end
        else
        begin
            if (wr_mode)
            begin
                // Host keeps other bits unchanged while running, so no guard here
                mode_q[15:1] <= mode_d[15:1];
            end
            if (done_evt || abort_req)
            begin
                mode_q[`TSW_MODE_START] <= 1'b0;
            end
            else if (start_req)
            begin
                mode_q[`TSW_MODE_START] <= 1'b1;
            end
        end
    end

    // Enable, reset and output enable registers; reserved bits masked off
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bp_enable_q <= 1'b0;
            rstctl_q <= `TSW_RSTCTL_RST;
            ocf_q <= `TSW_OCF_RST;
            ien_q <= 16'h0000;
        end
        else if (wr_fire)
        begin
            if (wr_idx == `TSW_IDX_BPCTL)
            begin
                bp_enable_q <= bpctl_d[`TSW_BPCTL_EN];
            end
            if (wr_idx == `TSW_IDX_RSTCTL)
            begin
                rstctl_q <= merge16(rstctl_q, s_axi_wdata, s_axi_wstrb, `TSW_RSTCTL_MASK);
            end
            if (wr_idx == `TSW_IDX_OUTEN)
            begin
                ocf_q <= merge16(ocf_q, s_axi_wdata, s_axi_wstrb, `TSW_OCF_MASK);
            end
            if (wr_idx == `TSW_IDX_IEN)
            begin
                ien_q <= merge16(ien_q, s_axi_wdata, s_axi_wstrb, `TSW_IRQ_MASK);
            end
        end
    end

    // Sticky events; a new event beats a clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stat_q <= 16'h0000;
        end
        else
        begin
            if (wr_fire && (wr_idx == `TSW_IDX_CLR))
            begin
                stat_q <= stat_q & ~merge16(16'h0000, s_axi_wdata, s_axi_wstrb, `TSW_IRQ_MASK);
            end
            if (done_evt)
            begin
                stat_q[`TSW_ST_DONE] <= 1'b1;
            end
            if (abort_req)
            begin
                stat_q[`TSW_ST_ABORT] <= 1'b1;
            end
        end
    end

    // Block programming drive and switch reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bp_active_q <= 1'b0;
            bp_pattern_q <= 3'h0;
            swrst_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            // Memory filler writes pattern into bits 2..0 while active
            bp_active_q <= (state_q == tsw_pkg::tsw_bp_run) && !abort_req && !done_evt;
            bp_pattern_q <= mode_q[`TSW_MODE_PAT_LSB +: 3];
            swrst_q <= rstctl_q[`TSW_RSTCTL_SWITCH];
            irq_q <= |(stat_q & ien_q);
        end
    end

    // Output pins; a disabled pin drops its enable and floats
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_off
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    offset_frame_pulse_o[gi] <= 1'b0;
                    offset_frame_pulse_oe[gi] <= 1'b0;
                end
                else
                begin
                    offset_frame_pulse_o[gi] <= offset_pulse_src[gi] && ocf_q[`TSW_OCF_OFF_LSB + gi];
                    offset_frame_pulse_oe[gi] <= ocf_q[`TSW_OCF_OFF_LSB + gi];
                end
            end
        end
        for (gi = 0; gi < 4; gi++)
        begin : g_ck
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    output_clock_o[gi] <= 1'b0;
                    output_clock_oe[gi] <= 1'b0;
                    output_frame_pulse_o[gi] <= 1'b0;
                    output_frame_pulse_oe[gi] <= 1'b0;
                end
                else
                begin
                    // Clock passes through a flop: a half-rate copy at most
                    output_clock_o[gi] <= clk_src[gi] && ocf_q[gi];
                    output_clock_oe[gi] <= ocf_q[gi];
                    output_frame_pulse_o[gi] <= frame_src[gi] && ocf_q[gi];
                    output_frame_pulse_oe[gi] <= ocf_q[gi];
                end
            end
        end
    endgenerate

    // Port drive, all from flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign bp_active = bp_active_q;
    assign bp_pattern = bp_pattern_q;
    assign switch_soft_reset = swrst_q;
    assign irq = irq_q;

    // Checks
    start_launch_a: assert property (@(posedge aclk) disable iff (!aresetn)
        start_req |=> (state_q == tsw_pkg::tsw_bp_run) ##1 bp_active)
        else $error("launch did not start a run");
    two_frames_a: assert property (@(posedge aclk) disable iff (!aresetn)
        done_evt |-> (frame_cnt_q == 2'h1) ##1 (state_q == tsw_pkg::tsw_bp_idle) && stat_q[0])
        else $error("run did not end on second frame");
    start_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        done_evt |=> !mode_q[0] ##1 !bp_active)
        else $error("start bit not cleared at end");
    abort_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
        abort_req |=> (state_q == tsw_pkg::tsw_bp_idle) && stat_q[1] && !mode_q[0])
        else $error("abort did not stop the run");
    soft_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(rstctl_q[1]) |=> switch_soft_reset [*2])
        else $error("switch reset not held");
    pattern_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bp_active |-> bp_pattern == $past(mode_q[3:1]))
        else $error("pattern not copied");
    offset_oe_a: assert property (@(posedge aclk) disable iff (!aresetn)
        offset_frame_pulse_oe[2] == $past(ocf_q[8]))
        else $error("offset pulse two enable wrong");
    clk_pulse_oe_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ocf_q[1] |=> !output_clock_oe[1] && !output_frame_pulse_oe[1])
        else $error("clock one not floated");
    reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (rstctl_q[0] == 1'b0) && (ocf_q[15:9] == 7'h00))
        else $error("reserved bit stored");
    write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire |=> s_axi_bvalid)
        else $error("no write response");
    run_done_c: cover property (@(posedge aclk) disable iff (!aresetn) done_evt);
    run_abort_c: cover property (@(posedge aclk) disable iff (!aresetn) abort_req);
    irq_rise_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));

endmodule

// ---- verification/tsw_mode_reset_tb.sv ----
/*
 * Self-checking bench for the TDM switch mode and reset register bank.
 * Assumes the design's register header is on the include path and a
 * single 10 MHz clock domain; the bench plays the AXI4-Lite master.
 */
`timescale 1ns/1ps
`include "tsw_regs.svh"

module tsw_mode_reset_tb;
    // Clock, reset and bus
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    // Frame timing, sources and pins
    logic frame_pulse = 1'b0;
    logic [2:0] offset_pulse_src = 3'h5;
    logic [3:0] clk_src = 4'hA, frame_src = 4'h6;
    logic bp_active, switch_soft_reset, irq;
    logic [2:0] bp_pattern, offset_frame_pulse_o, offset_frame_pulse_oe;
    logic [3:0] output_clock_o, output_clock_oe, output_frame_pulse_o, output_frame_pulse_oe;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [1:0] rs;

    tsw_mode_reset uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .frame_pulse(frame_pulse), .offset_pulse_src(offset_pulse_src), .clk_src(clk_src),
        .frame_src(frame_src), .bp_active(bp_active), .bp_pattern(bp_pattern),
        .switch_soft_reset(switch_soft_reset), .offset_frame_pulse_o(offset_frame_pulse_o),
        .offset_frame_pulse_oe(offset_frame_pulse_oe), .output_clock_o(output_clock_o),
        .output_clock_oe(output_clock_oe), .output_frame_pulse_o(output_frame_pulse_o),
        .output_frame_pulse_oe(output_frame_pulse_oe), .irq(irq));

    // Free-running 100 ns clock
    always #50 aclk = ~aclk;

    // Verdict in one place
    task tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Hang guard, well above the expected run of a few hundred cycles
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles >= 20000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    // Write: address and data offered together, each released when taken
    task axi_write(input logic [3:0] idx, input logic [15:0] data, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0000, data};
        s_axi_wstrb <= 4'h3;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        resp = 2'h3;
        // No latency assumed; only the hang guard ends a wait
        forever
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
            begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        // Response only after both channels were taken
        check("write channels released", {30'h0, s_axi_awvalid, s_axi_wvalid}, 32'h0);
    endtask

    task axi_read(input logic [3:0] idx, output logic [31:0] data, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        data = 32'hFFFFFFFF;
        resp = 2'h3;
        forever
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        check("read address released", {31'h0, s_axi_arvalid}, 32'h0);
    endtask

    // Write expecting an OKAY answer
    task wr(input logic [3:0] idx, input logic [15:0] data);
        axi_write(idx, data, rs);
        check("write resp", {30'h0, rs}, {30'h0, `TSW_RESP_OKAY});
    endtask

    task rd_chk(input logic [3:0] idx, input logic [31:0] exp, input string name);
        axi_read(idx, rd, rs);
        check(name, rd, exp);
        check("read resp", {30'h0, rs}, {30'h0, `TSW_RESP_OKAY});
    endtask

    // One-cycle frame pulse, then settle
    task frame_tick;
        @(posedge aclk);
        frame_pulse <= 1'b1;
        @(posedge aclk);
        frame_pulse <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values and unmapped access
        rd_chk(`TSW_IDX_MODE, 32'h0, "mode select reset");
        rd_chk(`TSW_IDX_RSTCTL, 32'h0, "soft reset reset");
        rd_chk(`TSW_IDX_OUTEN, 32'h0, "output enable reset");
        check("offset oe after reset", {29'h0, offset_frame_pulse_oe}, 32'h0);
        axi_read(4'hF, rd, rs);
        check("unmapped read resp", {30'h0, rs}, {30'h0, `TSW_RESP_SLVERR});
        check("unmapped read data", rd, 32'h0);
        axi_write(4'hF, 16'h1234, rs);
        check("unmapped write resp", {30'h0, rs}, {30'h0, `TSW_RESP_SLVERR});
        // Software reset of the switching blocks; reserved bits written zero
        check("switch running", {31'h0, switch_soft_reset}, 32'h0);
        wr(`TSW_IDX_RSTCTL, 16'h0002);
        rd_chk(`TSW_IDX_RSTCTL, 32'h2, "soft reset set");
        check("switch held", {31'h0, switch_soft_reset}, 32'h1);
        wr(`TSW_IDX_RSTCTL, 16'h0000);
        repeat (2) @(posedge aclk);
        check("switch released", {31'h0, switch_soft_reset}, 32'h0);
        // Output enables: all on, then offset pulse two with clock and frame pulse one, then all off
        wr(`TSW_IDX_OUTEN, 16'h01CF);
        repeat (3) @(posedge aclk);
        rd_chk(`TSW_IDX_OUTEN, 32'h01CF, "output enable all");
        check("offset oe all", {29'h0, offset_frame_pulse_oe}, 32'h7);
        check("offset out", {29'h0, offset_frame_pulse_o}, 32'h5);
        check("clock oe all", {28'h0, output_clock_oe}, 32'hF);
        check("clock out", {28'h0, output_clock_o}, 32'hA);
        check("frame oe all", {28'h0, output_frame_pulse_oe}, 32'hF);
        check("frame out", {28'h0, output_frame_pulse_o}, 32'h6);
        wr(`TSW_IDX_OUTEN, 16'h0102);
        repeat (3) @(posedge aclk);
        check("offset oe two only", {29'h0, offset_frame_pulse_oe}, 32'h4);
        check("clock oe one only", {28'h0, output_clock_oe}, 32'h2);
        check("frame oe one only", {28'h0, output_frame_pulse_oe}, 32'h2);
        wr(`TSW_IDX_OUTEN, 16'h0000);
        repeat (3) @(posedge aclk);
        check("offset oe off", {29'h0, offset_frame_pulse_oe}, 32'h0);
        check("clock oe off", {28'h0, output_clock_oe}, 32'h0);
        // Start while enable is low is ignored
        wr(`TSW_IDX_IEN, 16'h0003);
        wr(`TSW_IDX_MODE, 16'h000B);
        repeat (3) @(posedge aclk);
        check("no run without enable", {31'h0, bp_active}, 32'h0);
        // Full run: pattern 5, two frames, start clears itself
        wr(`TSW_IDX_BPCTL, 16'h0001);
        wr(`TSW_IDX_MODE, 16'h000B);
        repeat (3) @(posedge aclk);
        check("run active", {31'h0, bp_active}, 32'h1);
        check("run pattern", {29'h0, bp_pattern}, 32'h5);
        frame_tick();
        check("active after one frame", {31'h0, bp_active}, 32'h1);
        rd_chk(`TSW_IDX_MODE, 32'h000B, "start held mid run");
        wr(`TSW_IDX_MODE, 16'h000B);
        frame_tick();
        check("idle after two frames", {31'h0, bp_active}, 32'h0);
        rd_chk(`TSW_IDX_MODE, 32'h000A, "start self cleared");
        rd_chk(`TSW_IDX_STAT, 32'h1, "done status");
        check("irq on done", {31'h0, irq}, 32'h1);
        // Masking, then clearing, the interrupt
        wr(`TSW_IDX_IEN, 16'h0000);
        repeat (2) @(posedge aclk);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(`TSW_IDX_IEN, 16'h0003);
        wr(`TSW_IDX_CLR, 16'h0001);
        repeat (2) @(posedge aclk);
        check("irq cleared", {31'h0, irq}, 32'h0);
        rd_chk(`TSW_IDX_STAT, 32'h0, "status cleared");
        // Abort by writing the start bit low
        wr(`TSW_IDX_MODE, 16'h000D);
        repeat (3) @(posedge aclk);
        check("second run pattern", {29'h0, bp_pattern}, 32'h6);
        wr(`TSW_IDX_MODE, 16'h000C);
        repeat (3) @(posedge aclk);
        check("stopped by start low", {31'h0, bp_active}, 32'h0);
        rd_chk(`TSW_IDX_STAT, 32'h2, "abort status");
        check("irq on abort", {31'h0, irq}, 32'h1);
        wr(`TSW_IDX_CLR, 16'h0002);
        // Abort by writing the enable bit low; later frames do not finish it
        wr(`TSW_IDX_MODE, 16'h000D);
        repeat (3) @(posedge aclk);
        check("third run active", {31'h0, bp_active}, 32'h1);
        wr(`TSW_IDX_BPCTL, 16'h0000);
        repeat (3) @(posedge aclk);
        check("stopped by enable low", {31'h0, bp_active}, 32'h0);
        rd_chk(`TSW_IDX_MODE, 32'h000C, "start low after abort");
        frame_tick();
        frame_tick();
        rd_chk(`TSW_IDX_STAT, 32'h2, "no done after abort");
        tally_and_finish();
    end
endmodule
